// >>> hdl/obcl_pkg.sv
// Purpose: shared constants of the option byte configuration loader
// Assumes: 32-bit option words, four of them, byte and complement pairs
// Notes:   register offsets are byte addresses on the strobed register port
package obcl_pkg;
    localparam int          OBCL_WORDS         = 4;
    localparam int          OBCL_WIDX_W        = 2;
    localparam logic [31:0] OBCL_BASE_ADDR     = 32'h1FFFF800;
    localparam logic [31:0] OBCL_ADDR_USER_CFG = 32'h1FFFF800;
    localparam logic [31:0] OBCL_ADDR_STORAGE  = 32'h1FFFF804;
    localparam logic [31:0] OBCL_ADDR_WPROT_LO = 32'h1FFFF808;
    localparam logic [31:0] OBCL_ADDR_WPROT_HI = 32'h1FFFF80C;
    localparam logic [31:0] OBCL_ADDR_STATUS   = 32'h1FFFF810;
    localparam logic [31:0] OBCL_ADDR_WLOCK    = 32'h1FFFF814;
    localparam logic [31:0] OBCL_ADDR_LOAD     = 32'h1FFFF818;
    // byte lanes of one option word
    localparam int          OBCL_B0_LSB        = 0;
    localparam int          OBCL_B0N_LSB       = 8;
    localparam int          OBCL_B1_LSB        = 16;
    localparam int          OBCL_B1N_LSB       = 24;
    // option status register layout
    localparam int          OBCL_ST_ERR_BIT    = 0;
    localparam int          OBCL_ST_RLOCK_BIT  = 1;
    localparam int          OBCL_ST_USER_LSB   = 2;
    localparam int          OBCL_ST_USER_STORAGE_BYTE0_LSB  = 10;
    localparam int          OBCL_ST_USER_STORAGE_BYTE1_LSB  = 18;
    localparam int          OBCL_USER_WDG_BIT  = 0;
    localparam int          OBCL_USER_STOP_BIT = 1;
    localparam int          OBCL_USER_STBY_BIT = 2;
    localparam logic [7:0]  OBCL_UNPROTECT_KEY = 8'hA5;
    localparam logic [7:0]  OBCL_ERASED_BYTE   = 8'hFF;
    localparam logic [31:0] OBCL_ZERO_WORD     = 32'h00000000;
    localparam logic [1:0]  OBCL_LAST_WORD     = 2'h3;
    typedef enum logic [3:0] {
        OBCL_IDLE  = 4'h1,
        OBCL_REQ   = 4'h2,
        OBCL_WAIT  = 4'h4,
        OBCL_DONE  = 4'h8
    } obcl_state_t;
endpackage : obcl_pkg

// >>> hdl/obcl_pair_check.sv
// Purpose: split one option word into two bytes and check each complement
// Assumes: word laid out as byte0, ~byte0, byte1, ~byte1 from the bottom
// Notes:   purely combinational
`timescale 1ns/1ps
`default_nettype none
module obcl_pair_check (
    input  wire logic [31:0] i_word,
    output logic      [7:0]  o_byte0,
    output logic      [7:0]  o_byte1,
    output logic             o_ok0,
    output logic             o_ok1
);
    import obcl_pkg::*;
    wire logic [7:0] comp0;
    wire logic [7:0] comp1;
    assign o_byte0 = i_word[OBCL_B0_LSB +: 8];
    assign comp0   = i_word[OBCL_B0N_LSB +: 8];
    assign o_byte1 = i_word[OBCL_B1_LSB +: 8];
    assign comp1   = i_word[OBCL_B1N_LSB +: 8];
    assign o_ok0   = (o_byte0 == ~comp0);
    assign o_ok1   = (o_byte1 == ~comp1);
endmodule : obcl_pair_check
`default_nettype wire

// >>> hdl/obcl_loader.sv
// Purpose: load option words from the information block after reset and decode them
// Assumes: information block answers a read one or more cycles after o_ib_req
// Notes:   decoded values change only on a system reset, never on programming
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - option word holds byte0, ~byte0, byte1, ~byte1 from low to high
// - new option values act only after the loader reloads them on reset
// - options readable raw at storage words and via decoded status register
// - four option words at consecutive word addresses in fixed order
// - user byte copied to status bits 9..2; only three low bits meaningful
// - standby reset bit 0 makes reset on standby entry
// - stop reset bit 0 makes reset on stop entry
// - lowest user bit 0 hardware watchdog, 1 software watchdog
// - flash readable only when read lock byte holds unprotect key
// - read lock state reported in status bit 1
// - data byte0 to status bits 17..10, byte1 to 25..18
// - write lock byte0 to bits 7..0, byte1 to bits 15..8
// - bad read lock complement pair means read lock active
// - write lock bit 0 protects its page group, 1 leaves it open
module obcl_loader (
    input  wire logic        i_mclk,
    input  wire logic        i_reset,
    // information block read port
    output logic      [1:0]  o_ib_word,
    output logic             o_ib_req,
    input  wire logic        i_ib_valid,
    input  wire logic [31:0] i_ib_data,
    // register port
    input  wire logic [31:0] i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rdata,
    // power mode requests and decoded controls
    input  wire logic        i_stop_entry,
    input  wire logic        i_standby_entry,
    output logic             o_mode_reset,
    output logic             o_watchdog_hw_start,
    output logic             o_flash_read_allowed,
    output logic      [15:0] o_page_group_wlock,
    output logic             o_load_done
);
    import obcl_pkg::*;

    // ------------------------------------------------------------
    // load sequencer
    // ------------------------------------------------------------
    obcl_state_t       state;
    obcl_state_t       next_state;
    logic        [1:0] word_idx;
    logic       [31:0] raw_word [OBCL_WORDS];
    logic       [31:0] status_reg;
    logic       [31:0] wlock_reg;
    logic              released;

    wire logic         last_word;
    wire logic         take_word;
    assign last_word = (word_idx == OBCL_LAST_WORD);
    assign take_word = (state == OBCL_WAIT) && i_ib_valid;

    always_comb begin
        next_state = state;
        unique case (state)
            OBCL_IDLE: next_state = OBCL_REQ;
            OBCL_REQ:  next_state = OBCL_WAIT;
            OBCL_WAIT: begin
                if (i_ib_valid) begin
                    next_state = last_word ? OBCL_DONE : OBCL_REQ;
                end
            end
            OBCL_DONE: next_state = OBCL_DONE;
            default:   next_state = OBCL_IDLE;
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            state    <= OBCL_IDLE;
            word_idx <= 2'h0;
        end else begin
            state <= next_state;
            if (take_word && !last_word) begin
                word_idx <= word_idx + 2'h1;
            end
        end
    end

    assign o_ib_req  = (state == OBCL_REQ);
    assign o_ib_word = word_idx;

    // raw copies kept so software sees storage words as loaded
    genvar gi;
    generate
        for (gi = 0; gi < OBCL_WORDS; gi++) begin : g_raw
            always_ff @(posedge i_mclk) begin
                if (i_reset) begin
                    raw_word[gi] <= OBCL_ZERO_WORD;
                end else if (take_word && (word_idx == OBCL_WIDX_W'(gi))) begin
                    raw_word[gi] <= i_ib_data;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic [7:0] rlock_byte;
    logic [7:0] user_byte;
    logic [7:0] user_storage_byte0_byte;
    logic [7:0] user_storage_byte1_byte;
    logic [7:0] wl0_byte;
    logic [7:0] wl1_byte;
    logic       rlock_ok;
    logic       user_ok;
    logic       user_storage_byte0_ok;
    logic       user_storage_byte1_ok;
    logic       wl0_ok;
    logic       wl1_ok;

    obcl_pair_check u_pair_cfg (
        .i_word  (raw_word[0]),
        .o_byte0 (rlock_byte),
        .o_byte1 (user_byte),
        .o_ok0   (rlock_ok),
        .o_ok1   (user_ok)
    );

    obcl_pair_check u_pair_data (
        .i_word  (raw_word[1]),
        .o_byte0 (user_storage_byte0_byte),
        .o_byte1 (user_storage_byte1_byte),
        .o_ok0   (user_storage_byte0_ok),
        .o_ok1   (user_storage_byte1_ok)
    );

    obcl_pair_check u_pair_wl (
        .i_word  (raw_word[2]),
        .o_byte0 (wl0_byte),
        .o_byte1 (wl1_byte),
        .o_ok0   (wl0_ok),
        .o_ok1   (wl1_ok)
    );

    // an erased or corrupted pair keeps the lock: safe side wins
    wire logic       rlock_active;
    wire logic       pair_err;
    wire logic [7:0] user_eff;
    wire logic [7:0] wl0_eff;
    wire logic [7:0] wl1_eff;
    logic      [31:0] next_status;
    logic      [31:0] next_wlock;
    assign rlock_active = !(rlock_ok && (rlock_byte == OBCL_UNPROTECT_KEY));
    assign pair_err     = !(user_ok && user_storage_byte0_ok && user_storage_byte1_ok && wl0_ok && wl1_ok && rlock_ok);
    // a bad user pair falls back to the erased value, a bad write lock pair to zero (all eight groups of that byte protected)
    assign user_eff     = user_ok ? user_byte : OBCL_ERASED_BYTE;
    assign wl0_eff      = wl0_ok ? wl0_byte : OBCL_ZERO_WORD[7:0];
    assign wl1_eff      = wl1_ok ? wl1_byte : OBCL_ZERO_WORD[7:0];

    always_comb begin
        next_status = OBCL_ZERO_WORD;
        next_status[OBCL_ST_ERR_BIT]        = pair_err;
        next_status[OBCL_ST_RLOCK_BIT]      = rlock_active;
        next_status[OBCL_ST_USER_LSB +: 8]  = user_eff;
        next_status[OBCL_ST_USER_STORAGE_BYTE0_LSB +: 8] = user_storage_byte0_byte;
        next_status[OBCL_ST_USER_STORAGE_BYTE1_LSB +: 8] = user_storage_byte1_byte;
    end

    always_comb begin
        next_wlock = OBCL_ZERO_WORD;
        next_wlock[OBCL_B0_LSB +: 8]  = wl0_eff;
        next_wlock[OBCL_B0N_LSB +: 8] = wl1_eff;
    end

    // ------------------------------------------------------------
    // decoded registers, frozen until the next reset
    // ------------------------------------------------------------
    wire logic        release_now;
    wire logic [31:0] status_at_reset;
    assign release_now     = (state == OBCL_DONE) && !released;
    // before the load the read lock reads active, the safe state
    assign status_at_reset = OBCL_ZERO_WORD | (32'h00000001 << OBCL_ST_RLOCK_BIT);

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            released   <= 1'b0;
            status_reg <= status_at_reset;
            wlock_reg  <= OBCL_ZERO_WORD;
        end else if (release_now) begin
            released   <= 1'b1;
            status_reg <= next_status;
            wlock_reg  <= next_wlock;
        end
    end

    // ------------------------------------------------------------
    // decoded controls
    // ------------------------------------------------------------
    wire logic stby_reset_en;
    wire logic stop_reset_en;
    wire logic [7:0] user_cur;
    assign user_cur      = status_reg[OBCL_ST_USER_LSB +: 8];
    assign stby_reset_en = !user_cur[OBCL_USER_STBY_BIT];
    assign stop_reset_en = !user_cur[OBCL_USER_STOP_BIT];

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            o_mode_reset <= 1'b0;
        end else begin
            o_mode_reset <= released &&
                            ((i_standby_entry && stby_reset_en) ||
                             (i_stop_entry && stop_reset_en));
        end
    end

    // before release everything reads locked and hardware watchdog
    assign o_watchdog_hw_start  = !released || !user_cur[OBCL_USER_WDG_BIT];
    assign o_flash_read_allowed = released && !status_reg[OBCL_ST_RLOCK_BIT];
    assign o_page_group_wlock   = ~wlock_reg[15:0];
    assign o_load_done          = released;

    // ------------------------------------------------------------
    // register read port; writes are ignored, options are read-only
    // ------------------------------------------------------------
    wire logic        hit_user_cfg;
    wire logic        hit_storage;
    wire logic        hit_wprot_lo;
    wire logic        hit_wprot_hi;
    wire logic        hit_status;
    wire logic        hit_wlock;
    wire logic        hit_load;
    wire logic [31:0] load_word;
    wire logic [31:0] next_rdata;
    assign hit_user_cfg = (i_addr == OBCL_ADDR_USER_CFG);
    assign hit_storage  = (i_addr == OBCL_ADDR_STORAGE);
    assign hit_wprot_lo = (i_addr == OBCL_ADDR_WPROT_LO);
    assign hit_wprot_hi = (i_addr == OBCL_ADDR_WPROT_HI);
    assign hit_status   = (i_addr == OBCL_ADDR_STATUS);
    assign hit_wlock    = (i_addr == OBCL_ADDR_WLOCK);
    assign hit_load     = (i_addr == OBCL_ADDR_LOAD);
    assign load_word    = {31'h00000000, released};
    // addresses never overlap, so an and-or select needs no priority; unmapped reads give zero
    assign next_rdata   = ({32{hit_user_cfg}} & raw_word[0])
                        | ({32{hit_storage}}  & raw_word[1])
                        | ({32{hit_wprot_lo}} & raw_word[2])
                        | ({32{hit_wprot_hi}} & raw_word[3])
                        | ({32{hit_status}}   & status_reg)
                        | ({32{hit_wlock}}    & wlock_reg)
                        | ({32{hit_load}}     & load_word);

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            o_rdata <= OBCL_ZERO_WORD;
        end else if (i_rd) begin
            o_rdata <= next_rdata;
        end else begin
            o_rdata <= OBCL_ZERO_WORD;
        end
    end

    // user data is changed only by the option programming sequence outside this block
    wire logic unused_ok;
    assign unused_ok = i_wr ^ (|i_wdata) ^ (|raw_word[3]);
endmodule : obcl_loader
`default_nettype wire

// >>> test/obcl_ib_model.sv
// Purpose: information block partner returning option words on request
// Assumes: one request outstanding at a time, latency set by the bench
// Notes:   data lines show the inverse once valid drops, never the held word
`timescale 1ns/1ps
`default_nettype none
module obcl_ib_model (
    input  wire logic         i_mclk,
    input  wire logic         i_req,
    input  wire logic [1:0]   i_word,
    input  wire logic [127:0] i_mem,
    input  wire logic [3:0]   i_lat,
    output logic              o_valid,
    output logic      [31:0]  o_data
);
    initial begin
        o_valid = 1'b0;
        o_data  = 32'h0;
        forever begin
            @(posedge i_mclk);
            if (i_req) begin
                repeat (i_lat) @(posedge i_mclk);
                o_valid <= 1'b1;
                o_data  <= i_mem[{i_word, 5'h00} +: 32];
                @(posedge i_mclk);
                o_valid <= 1'b0;
                o_data  <= ~o_data;
            end
        end
    end
endmodule : obcl_ib_model
`default_nettype wire

// >>> test/obcl_loader_checker.sv
// Purpose: port assertions for the option byte loader
// Assumes: one clock, synchronous active high reset
// Notes:   bound to every loader instance
`timescale 1ns/1ps
`default_nettype none
module obcl_loader_checker (
    input wire logic        i_mclk,
    input wire logic        i_reset,
    input wire logic [1:0]  o_ib_word,
    input wire logic        o_ib_req,
    input wire logic        i_ib_valid,
    input wire logic [31:0] i_ib_data,
    input wire logic [31:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic        i_stop_entry,
    input wire logic        i_standby_entry,
    input wire logic        o_mode_reset,
    input wire logic        o_watchdog_hw_start,
    input wire logic        o_flash_read_allowed,
    input wire logic [15:0] o_page_group_wlock,
    input wire logic        o_load_done
);
    import obcl_pkg::*;
    logic [1:0] req_cnt;
    // counting requests checks the word order without a model of the data
    always_ff @(posedge i_mclk) begin
        if (i_reset) req_cnt <= 2'h0;
        else if (o_ib_req) req_cnt <= req_cnt + 2'h1;
    end
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_reset);
    property p_req_pulse; o_ib_req |=> !o_ib_req; endproperty
    a_req_pulse: assert property (p_req_pulse) else $error("request longer than one cycle");
    property p_order; o_ib_req |-> o_ib_word == req_cnt; endproperty
    a_order: assert property (p_order) else $error("option word out of order");
    property p_quiet; o_load_done |-> !o_ib_req; endproperty
    a_quiet: assert property (p_quiet) else $error("request after load");
    property p_bound; $fell(i_reset) |-> ##[0:100] o_load_done; endproperty
    a_bound: assert property (p_bound) else $error("load never finished");
    property p_hold; o_load_done |=> o_load_done && $stable({o_page_group_wlock, o_flash_read_allowed}); endproperty
    a_hold: assert property (p_hold) else $error("decoded value moved after load");
    property p_pre; !o_load_done |-> !o_flash_read_allowed && o_watchdog_hw_start && !o_mode_reset; endproperty
    a_pre: assert property (p_pre) else $error("controls released before load");
    property p_idle; !i_rd |=> o_rdata == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("read data without read");
    property p_st; i_rd && i_addr == OBCL_ADDR_STATUS && o_load_done
        |=> o_rdata[1] == !o_flash_read_allowed && o_rdata[2] == !o_watchdog_hw_start; endproperty
    a_st: assert property (p_st) else $error("status bits disagree with pins");
    property p_wl; i_rd && i_addr == OBCL_ADDR_WLOCK && o_load_done |=> o_rdata == {16'h0, ~o_page_group_wlock};
    endproperty
    a_wl: assert property (p_wl) else $error("write lock status disagrees with pins");
    property p_mr; o_mode_reset |-> $past(o_load_done) && $past(i_stop_entry | i_standby_entry); endproperty
    a_mr: assert property (p_mr) else $error("mode reset without entry");
    c_load: cover property ($rose(o_load_done));
    c_mr: cover property (o_mode_reset);
    c_st: cover property (i_rd && i_addr == OBCL_ADDR_STATUS && o_load_done);
endmodule : obcl_loader_checker
bind obcl_loader obcl_loader_checker u_chk (.i_mclk, .i_reset, .o_ib_word, .o_ib_req, .i_ib_valid, .i_ib_data,
    .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_stop_entry, .i_standby_entry, .o_mode_reset,
    .o_watchdog_hw_start, .o_flash_read_allowed, .o_page_group_wlock, .o_load_done);
`default_nettype wire

// >>> test/tb_option_byte_config_loader.sv
// Purpose: self-checking bench for the option byte loader
// Assumes: partner answers each request after a random latency
// Notes:   every pass programs and reloads a fresh random option image
`timescale 1ns/1ps
`default_nettype none
module tb_option_byte_config_loader;
    import obcl_pkg::*;
    logic        i_mclk = 1'b0;
    logic        i_reset = 1'b1;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    logic        i_stop_entry = 1'b0;
    logic        i_standby_entry = 1'b0;
    logic [31:0] i_addr = 32'h0;
    logic [31:0] i_wdata = 32'h0;
    logic [3:0]  lat = 4'h0;
    logic        i_ib_valid, o_ib_req, o_mode_reset, o_watchdog_hw_start, o_flash_read_allowed, o_load_done;
    logic [1:0]  o_ib_word;
    logic [15:0] o_page_group_wlock;
    logic [31:0] i_ib_data, o_rdata, st, wl, u, v;
    logic [31:0] w [4];
    logic [63:0] f;
    logic [127:0] mem;
    integer      seed = 36906;
    integer      n_errors = 0;
    integer      check_count = 0;
    always #5 i_mclk = ~i_mclk;
    assign mem = {w[3], w[2], w[1], w[0]};
    obcl_loader dut (.i_mclk, .i_reset, .o_ib_word, .o_ib_req, .i_ib_valid, .i_ib_data, .i_addr, .i_wdata,
        .i_wr, .i_rd, .o_rdata, .i_stop_entry, .i_standby_entry, .o_mode_reset, .o_watchdog_hw_start,
        .o_flash_read_allowed, .o_page_group_wlock, .o_load_done);
    obcl_ib_model u_ib (.i_mclk(i_mclk), .i_req(o_ib_req), .i_word(o_ib_word), .i_mem(mem), .i_lat(lat),
        .o_valid(i_ib_valid), .o_data(i_ib_data));
    function automatic logic [31:0] pw(input logic [7:0] b0, input logic [7:0] b1, input logic [15:0] x);
        return {~b1 ^ x[15:8], b1, ~b0 ^ x[7:0], b0};
    endfunction : pw
    function automatic logic ok(input logic [31:0] x, input int h);
        return x[h*16+8 +: 8] === ~x[h*16 +: 8];
    endfunction : ok
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        @(posedge i_mclk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1 chk(o_rdata, exp);
    endtask : rd
    task automatic entry(input int sel, input logic exp);
        @(posedge i_mclk);
        if (sel) i_standby_entry <= 1'b1;
        else i_stop_entry <= 1'b1;
        @(posedge i_mclk);
        i_standby_entry <= 1'b0;
        i_stop_entry <= 1'b0;
        #1 chk({31'h0, o_mode_reset}, {31'h0, exp});
    endtask : entry
    task automatic conclude;
        if (n_errors == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : conclude
    initial begin
        for (int k = 0; k < 8; k++) begin
            @(posedge i_mclk);
            u = $random(seed);
            v = $random(seed);
            // later passes break complements to reach the fallback decodes
            f = (k > 4) ? {$random(seed), $random(seed)} : 64'h0;
            w[0] = pw((k % 2) ? OBCL_UNPROTECT_KEY : u[7:0], {v[31:27], 3'(k)}, f[15:0]);
            w[1] = pw(u[15:8], u[23:16], f[31:16]);
            w[2] = pw(u[31:24], v[7:0], f[47:32]);
            w[3] = pw(v[15:8], v[23:16], 16'h0);
            st = {6'h0, w[1][23:16], w[1][7:0], ok(w[0], 1) ? w[0][23:16] : 8'hFF,
                !(ok(w[0], 0) && w[0][7:0] === OBCL_UNPROTECT_KEY),
                !(ok(w[0], 0) && ok(w[0], 1) && ok(w[1], 0) && ok(w[1], 1) && ok(w[2], 0) && ok(w[2], 1))};
            wl = {16'h0, ok(w[2], 1) ? w[2][23:16] : 8'h0, ok(w[2], 0) ? w[2][7:0] : 8'h0};
            lat <= {2'h0, v[25:24]};
            i_reset <= 1'b1;
            repeat (10) @(posedge i_mclk);
            i_reset <= 1'b0;
            for (int i = 0; i < 100 && o_load_done !== 1'b1; i++) @(posedge i_mclk);
            #1 chk({31'h0, o_load_done}, 32'h1);
            for (int j = 0; j < 4; j++) rd(OBCL_ADDR_USER_CFG + 32'(4 * j), w[j]);
            rd(OBCL_ADDR_STATUS, st);
            rd(OBCL_ADDR_WLOCK, wl);
            rd(OBCL_ADDR_LOAD, 32'h1);
            rd(OBCL_ADDR_LOAD + 32'h4, 32'h0);
            chk({14'h0, o_page_group_wlock, o_flash_read_allowed, o_watchdog_hw_start},
                {14'h0, ~wl[15:0], !st[1], !st[2]});
            entry(0, !st[3]);
            entry(1, !st[4]);
            w[1] = ~w[1];
            @(posedge i_mclk);
            i_wr <= 1'b1;
            i_addr <= OBCL_ADDR_STATUS;
            i_wdata <= $random(seed);
            @(posedge i_mclk);
            i_wr <= 1'b0;
            rd(OBCL_ADDR_STATUS, st);
        end
        conclude();
    end
    initial begin
        #50000;
        n_errors++;
        conclude();
    end
endmodule : tb_option_byte_config_loader
`default_nettype wire
